/* include/flash_host_pkg.sv */
// Package of constants and types shared by the parallel flash host controller.
package flash_host_pkg;

  // Pin and word widths of the flash bus.
  localparam int ADDR_W = 21;
  localparam int DATA_W = 8;
  localparam int SECTOR_W = 5;
  localparam int SECTOR_LSB = 16;

  // Clock rate in kHz; one cycle is 100 ns.
  localparam int CLK_KHZ = 10000;

  // Bus timing figures in ns, as documented or chosen for a slow part.
  localparam int ADDR_ACCESS_NS = 120;
  localparam int SELECT_ACCESS_NS = 120;
  localparam int WRITE_PULSE_NS = 50;
  localparam int WRITE_HIGH_NS = 30;
  localparam int MIN_CLEAR_PULSE_NS = 500;
  localparam int CLEAR_RECOVERY_NS = 50;
  localparam int CLEAR_SETTLE_NS = 20000;

  // Conversion of a least time in ns into whole cycles, never below one.
  function automatic int ns_to_cycles(input int ns);
    int c;
    c = (ns * (CLK_KHZ / 1000) + 999) / 1000;
    return (c < 1) ? 1 : c;
  endfunction : ns_to_cycles

  // Cycle counts derived from the times above.
  localparam int READ_CYC = ns_to_cycles(SELECT_ACCESS_NS);
  localparam int WRITE_LOW_CYC = ns_to_cycles(WRITE_PULSE_NS);
  localparam int WRITE_HIGH_CYC = ns_to_cycles(WRITE_HIGH_NS);
  localparam int CLEAR_PULSE_CYC = ns_to_cycles(MIN_CLEAR_PULSE_NS);
  localparam int CLEAR_RECOVERY_CYC = ns_to_cycles(CLEAR_RECOVERY_NS);
  localparam int CLEAR_SETTLE_CYC = ns_to_cycles(CLEAR_SETTLE_NS);
  localparam int CNT_W = 8;

  // Unlock and command sequence constants.
  localparam logic [ADDR_W-1:0] UNLOCK_ADDR_A = 21'h000555;
  localparam logic [ADDR_W-1:0] UNLOCK_ADDR_B = 21'h0002AA;
  localparam logic [DATA_W-1:0] UNLOCK_DATA_A = 8'hAA;
  localparam logic [DATA_W-1:0] UNLOCK_DATA_B = 8'h55;
  localparam logic [DATA_W-1:0] CMD_PROGRAM = 8'hA0;
  localparam logic [DATA_W-1:0] CMD_ERASE_SETUP = 8'h80;
  localparam logic [DATA_W-1:0] CMD_CHIP_ERASE = 8'h10;
  localparam logic [DATA_W-1:0] CMD_SECTOR_ERASE = 8'h30;
  localparam logic [DATA_W-1:0] CMD_IDENT = 8'h90;
  localparam logic [DATA_W-1:0] CMD_BYPASS = 8'h20;
  localparam logic [DATA_W-1:0] CMD_BYPASS_EXIT0 = 8'h90;
  localparam logic [DATA_W-1:0] CMD_BYPASS_EXIT1 = 8'h00;
  localparam logic [DATA_W-1:0] CMD_READ_ARRAY = 8'hF0;

  // Requests that the user side may make.
  typedef enum logic [3:0] {
    OP_READ,
    OP_PROGRAM,
    OP_SECTOR_ERASE,
    OP_CHIP_ERASE,
    OP_IDENT,
    OP_BYPASS_ENTER,
    OP_BYPASS_EXIT,
    OP_READ_ARRAY,
    OP_CLEAR
  } op_e;

endpackage : flash_host_pkg

/* logic/flash_bus_cycle.sv */
// One flash bus cycle: a timed read or write on the shared pins.
`timescale 1ns/1ns
module flash_bus_cycle
  import flash_host_pkg::*;
(
  // Clock and reset.
  input  wire logic              mclk_in,
  input  wire logic              reset_in,
  // Cycle request.
  input  wire logic              start_in,
  input  wire logic              write_in,
  input  wire logic [ADDR_W-1:0] addr_in,
  input  wire logic [DATA_W-1:0] wdata_in,
  output logic                   done_out,
  output logic [DATA_W-1:0]      rdata_out,
  // Flash pins.
  output logic [ADDR_W-1:0]      addr_out,
  output logic                   chip_select_n_out,
  output logic                   write_strobe_n_out,
  output logic                   output_gate_n_out,
  output logic [DATA_W-1:0]      data_pins_out,
  output logic                   data_pins_oe_n_out,
  input  wire logic [DATA_W-1:0] data_pins_in
);

  typedef enum logic [1:0] {CY_IDLE, CY_LOW, CY_HIGH} cyc_e;

  typedef struct packed {
    cyc_e              st;
    logic              wr;
    logic [CNT_W-1:0]  cnt;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [DATA_W-1:0] rdata;
    logic              done;
  } cyc_s;

  cyc_s r;
  cyc_s next_r;

  // Sequencer: strobe low phase, then a recovery high phase before done.
  always_comb begin
    next_r = r;
    next_r.done = 1'b0;
    unique case (r.st)
      CY_IDLE: begin
        if (start_in) begin
          next_r.st = CY_LOW;
          next_r.wr = write_in;
          next_r.addr = addr_in;
          next_r.wdata = wdata_in;
          next_r.cnt = write_in ? CNT_W'(WRITE_LOW_CYC) : CNT_W'(READ_CYC + 1);
        end
      end
      CY_LOW: begin
        if (r.cnt == CNT_W'(1)) begin
          if (!r.wr) begin
            next_r.rdata = data_pins_in;
          end
          next_r.st = CY_HIGH;
          next_r.cnt = CNT_W'(WRITE_HIGH_CYC);
        end else begin
          next_r.cnt = r.cnt - CNT_W'(1);
        end
      end
      CY_HIGH: begin
        if (r.cnt == CNT_W'(1)) begin
          next_r.st = CY_IDLE;
          next_r.done = 1'b1;
        end else begin
          next_r.cnt = r.cnt - CNT_W'(1);
        end
      end
    endcase
  end

  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      r <= '{st: CY_IDLE, wr: 1'b0, cnt: '0, addr: '0, wdata: '0, rdata: '0, done: 1'b0};
    end else begin
      r <= next_r;
    end
  end

  // Pins follow the phase; the gate stays high on writes so no contention.
  assign done_out = r.done;
  assign rdata_out = r.rdata;
  assign addr_out = r.addr;
  assign chip_select_n_out = (r.st != CY_LOW);
  assign write_strobe_n_out = !(r.st == CY_LOW && r.wr);
  assign output_gate_n_out = !(r.st == CY_LOW && !r.wr);
  assign data_pins_out = r.wdata;
  assign data_pins_oe_n_out = !(r.st != CY_IDLE && r.wr);

endmodule : flash_bus_cycle

/* logic/flash_host_ctrl.sv */
// Host controller that drives a parallel flash through its pins.
`timescale 1ns/1ns
module flash_host_ctrl
  import flash_host_pkg::*;
(
  // Clock and reset.
  input  wire logic                mclk_in,
  input  wire logic                reset_in,
  // User request side.
  input  wire logic                req_valid_in,
  input  wire op_e                 req_op_in,
  input  wire logic [ADDR_W-1:0]   req_addr_in,
  input  wire logic [DATA_W-1:0]   req_data_in,
  input  wire logic [SECTOR_W-1:0] req_sector_in,
  input  wire logic                req_more_in,
  output logic                     req_ready_out,
  output logic                     resp_valid_out,
  output logic [DATA_W-1:0]        resp_data_out,
  output logic                     bypass_mode_out,
  output logic                     ident_mode_out,
  output logic                     interrupted_out,
  // Flash pins.
  output logic [ADDR_W-1:0]        addr_out,
  output logic                     chip_select_n_out,
  output logic                     write_strobe_n_out,
  output logic                     output_gate_n_out,
  output logic                     hard_clear_n_out,
  output logic [DATA_W-1:0]        data_pins_out,
  output logic                     data_pins_oe_n_out,
  input  wire logic [DATA_W-1:0]   data_pins_in,
  input  wire logic                ready_busy_in
);

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_WRITE,
    ST_WAIT_WR,
    ST_READ,
    ST_CLEAR_LOW,
    ST_CLEAR_SETTLE,
    ST_CLEAR_RECOVER
  } st_e;

  typedef struct packed {
    st_e               st;
    op_e               op;
    logic [2:0]        step;
    logic [2:0]        last;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic              more;
    logic              bypass;
    logic              ident;
    logic              interrupted;
    logic [CNT_W-1:0]  cnt;
    logic [7:0]        settle_hi;
    logic              clear_n;
    logic              resp_v;
    logic [DATA_W-1:0] resp_d;
  } ctl_s;

  ctl_s r;
  ctl_s next_r;

  logic              cyc_start;
  logic              cyc_write;
  logic [ADDR_W-1:0] cyc_addr;
  logic [DATA_W-1:0] cyc_wdata;
  logic              cyc_done;
  logic [DATA_W-1:0] cyc_rdata;

  // Sector base address: the index goes on the top five address lines.
  function automatic logic [ADDR_W-1:0] sector_base(input logic [SECTOR_W-1:0] s);
    return {s, {SECTOR_LSB{1'b0}}};
  endfunction : sector_base

  // Address and data of one write of a command sequence, by step number.
  function automatic logic [ADDR_W+DATA_W-1:0] seq_word(input op_e op, input logic [2:0] step,
                                                        input logic byp, input logic more,
                                                        input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    logic [ADDR_W+DATA_W-1:0] w;
    w = {UNLOCK_ADDR_A, CMD_READ_ARRAY};
    unique case (op)
      OP_PROGRAM: begin
        if (byp) begin
          w = (step == 3'd0) ? {UNLOCK_ADDR_A, CMD_PROGRAM} : {a, d};
        end else begin
          unique case (step)
            3'd0: w = {UNLOCK_ADDR_A, UNLOCK_DATA_A};
            3'd1: w = {UNLOCK_ADDR_B, UNLOCK_DATA_B};
            3'd2: w = {UNLOCK_ADDR_A, CMD_PROGRAM};
            default: w = {a, d};
          endcase
        end
      end
      OP_SECTOR_ERASE, OP_CHIP_ERASE: begin
        unique case (step)
          3'd0, 3'd3: w = {UNLOCK_ADDR_A, UNLOCK_DATA_A};
          3'd1, 3'd4: w = {UNLOCK_ADDR_B, UNLOCK_DATA_B};
          3'd2: w = {UNLOCK_ADDR_A, CMD_ERASE_SETUP};
          default: w = (op == OP_CHIP_ERASE) ? {UNLOCK_ADDR_A, CMD_CHIP_ERASE}
                                             : {a, CMD_SECTOR_ERASE};
        endcase
        if (more && op == OP_SECTOR_ERASE) begin
          w = {a, CMD_SECTOR_ERASE};
        end
      end
      OP_IDENT, OP_BYPASS_ENTER: begin
        unique case (step)
          3'd0: w = {UNLOCK_ADDR_A, UNLOCK_DATA_A};
          3'd1: w = {UNLOCK_ADDR_B, UNLOCK_DATA_B};
          default: w = {UNLOCK_ADDR_A, (op == OP_IDENT) ? CMD_IDENT : CMD_BYPASS};
        endcase
      end
      OP_BYPASS_EXIT: w = (step == 3'd0) ? {UNLOCK_ADDR_A, CMD_BYPASS_EXIT0} : {UNLOCK_ADDR_A, CMD_BYPASS_EXIT1};
      default: w = {UNLOCK_ADDR_A, CMD_READ_ARRAY};
    endcase
    return w;
  endfunction : seq_word

  // Number of writes minus one that a request needs.
  function automatic logic [2:0] seq_last(input op_e op, input logic byp, input logic more);
    logic [2:0] n;
    n = 3'd0;
    unique case (op)
      OP_PROGRAM: n = byp ? 3'd1 : 3'd3;
      OP_SECTOR_ERASE: n = more ? 3'd0 : 3'd5;
      OP_CHIP_ERASE: n = 3'd5;
      OP_IDENT, OP_BYPASS_ENTER: n = 3'd2;
      OP_BYPASS_EXIT: n = 3'd1;
      default: n = 3'd0;
    endcase
    return n;
  endfunction : seq_last

  // Main sequencer. Program and erase end once their last write cycle is done, without waiting for the busy pin.
  always_comb begin
    next_r = r;
    next_r.resp_v = 1'b0;
    cyc_start = 1'b0;
    cyc_write = 1'b0;
    {cyc_addr, cyc_wdata} = seq_word(r.op, r.step, r.bypass, r.more, r.addr, r.data);
    unique case (r.st)
      ST_IDLE: begin
        if (req_valid_in) begin
          next_r.op = req_op_in;
          next_r.more = req_more_in;
          next_r.step = 3'd0;
          next_r.data = req_data_in;
          next_r.addr = (req_op_in == OP_SECTOR_ERASE) ? sector_base(req_sector_in) : req_addr_in;
          next_r.last = seq_last(req_op_in, r.bypass, req_more_in);
          unique case (req_op_in)
            OP_CLEAR: begin
              next_r.st = ST_CLEAR_LOW;
              next_r.clear_n = 1'b0;
              next_r.cnt = CNT_W'(CLEAR_PULSE_CYC);
              next_r.interrupted = !ready_busy_in;
            end
            OP_READ: next_r.st = ST_READ;
            OP_PROGRAM, OP_SECTOR_ERASE, OP_CHIP_ERASE: begin
              next_r.st = ST_WRITE;
              next_r.interrupted = 1'b0;
            end
            default: next_r.st = ST_WRITE;
          endcase
        end
      end
      ST_WRITE: begin
        cyc_start = 1'b1;
        cyc_write = 1'b1;
        next_r.st = ST_WAIT_WR;
      end
      ST_WAIT_WR: begin
        if (cyc_done) begin
          if (r.step != r.last) begin
            next_r.step = r.step + 3'd1;
            next_r.st = ST_WRITE;
          end else begin
            unique case (r.op)
              OP_IDENT: next_r.ident = 1'b1;
              OP_BYPASS_ENTER: next_r.bypass = 1'b1;
              OP_BYPASS_EXIT: next_r.bypass = 1'b0;
              OP_READ_ARRAY: next_r.ident = 1'b0;
              default: next_r.ident = r.ident;
            endcase
            next_r.resp_v = 1'b1;
            next_r.st = ST_IDLE;
          end
        end
      end
      ST_READ: begin
        cyc_start = 1'b1;
        {cyc_addr, cyc_wdata} = {r.addr, r.data};
        next_r.st = ST_CLEAR_RECOVER;
        next_r.cnt = '0;
      end
      ST_CLEAR_LOW: begin
        if (r.cnt == CNT_W'(1)) begin
          next_r.clear_n = 1'b1;
          next_r.st = ST_CLEAR_SETTLE;
          next_r.cnt = CNT_W'(CLEAR_RECOVERY_CYC);
          next_r.settle_hi = 8'(CLEAR_SETTLE_CYC);
        end else begin
          next_r.cnt = r.cnt - CNT_W'(1);
        end
      end
      ST_CLEAR_SETTLE: begin
        // Wait recovery, then for busy to rise, bounded by the settle time.
        if (r.cnt != '0) begin
          next_r.cnt = r.cnt - CNT_W'(1);
        end else if (ready_busy_in || r.settle_hi == 8'h00) begin
          next_r.ident = 1'b0;
          next_r.bypass = 1'b0;
          next_r.resp_v = 1'b1;
          next_r.st = ST_IDLE;
        end else begin
          next_r.settle_hi = r.settle_hi - 8'h01;
        end
      end
      ST_CLEAR_RECOVER: begin
        // Read in flight: return data when the cycle completes.
        if (cyc_done) begin
          next_r.resp_v = 1'b1;
          next_r.resp_d = cyc_rdata;
          next_r.st = ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      r <= '{st: ST_IDLE, op: OP_READ, step: 3'd0, last: 3'd0, addr: '0, data: '0, more: 1'b0,
             bypass: 1'b0, ident: 1'b0, interrupted: 1'b0, cnt: '0, settle_hi: 8'h00,
             clear_n: 1'b0, resp_v: 1'b0, resp_d: '0};
    end else begin
      r <= next_r;
    end
  end

  // Timed bus cycle engine; chip select high between cycles gives standby.
  flash_bus_cycle u_cycle (
    .mclk_in            (mclk_in),
    .reset_in           (reset_in),
    .start_in           (cyc_start),
    .write_in           (cyc_write),
    .addr_in            (cyc_addr),
    .wdata_in           (cyc_wdata),
    .done_out           (cyc_done),
    .rdata_out          (cyc_rdata),
    .addr_out           (addr_out),
    .chip_select_n_out  (chip_select_n_out),
    .write_strobe_n_out (write_strobe_n_out),
    .output_gate_n_out  (output_gate_n_out),
    .data_pins_out      (data_pins_out),
    .data_pins_oe_n_out (data_pins_oe_n_out),
    .data_pins_in       (data_pins_in)
  );

  // The clear pin is held low through reset so the flash starts clean.
  assign hard_clear_n_out = r.clear_n;
  assign req_ready_out = (r.st == ST_IDLE);
  assign resp_valid_out = r.resp_v;
  assign resp_data_out = r.resp_d;
  assign bypass_mode_out = r.bypass;
  assign ident_mode_out = r.ident;
  assign interrupted_out = r.interrupted;

endmodule : flash_host_ctrl

/* verif/flash_host_checker.sv */
// Pin protocol checker for the flash host controller.
`timescale 1ns/1ns
module flash_host_checker
  import flash_host_pkg::*;
(
  // Clock and reset.
  input wire logic              mclk_in,
  input wire logic              reset_in,
  // User side.
  input wire logic              req_valid_in,
  input wire op_e               req_op_in,
  input wire logic              req_ready_out,
  input wire logic              resp_valid_out,
  input wire logic              bypass_mode_out,
  // Flash pins.
  input wire logic [ADDR_W-1:0] addr_out,
  input wire logic              chip_select_n_out,
  input wire logic              write_strobe_n_out,
  input wire logic              output_gate_n_out,
  input wire logic              hard_clear_n_out,
  input wire logic [DATA_W-1:0] data_pins_out,
  input wire logic              data_pins_oe_n_out
);
  logic       prog_op;
  logic       byp_at;
  logic [3:0] n_wr;
  logic [7:0] low_cnt;

  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (reset_in);

  // Counts write strobes of a program request and the length of each clear pulse.
  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      prog_op <= 1'b0;
      byp_at  <= 1'b0;
      n_wr    <= 4'h0;
      low_cnt <= 8'h00;
    end else begin
      if (req_valid_in && req_ready_out) begin
        prog_op <= (req_op_in == OP_PROGRAM);
        byp_at  <= bypass_mode_out;
        n_wr    <= 4'h0;
      end else if (!write_strobe_n_out && n_wr != 4'hF) begin
        n_wr <= n_wr + 4'h1;
      end
      low_cnt <= hard_clear_n_out ? 8'h00 : ((low_cnt == 8'hFF) ? low_cnt : low_cnt + 8'h01);
    end
  end

  write_ctl_a: assert property (!write_strobe_n_out |-> !chip_select_n_out && output_gate_n_out)
    else $error("write strobe low without select low and gate high");
  read_ctl_a: assert property (!output_gate_n_out |-> !chip_select_n_out && write_strobe_n_out)
    else $error("output gate low outside a read");
  no_fight_a: assert property (!data_pins_oe_n_out |-> output_gate_n_out)
    else $error("host drives data while device outputs are on");
  wr_hold_a: assert property ($rose(write_strobe_n_out) |-> $stable(addr_out) && $stable(data_pins_out)
    && !data_pins_oe_n_out)
    else $error("address or data moved during write pulse");
  wr_gap_a: assert property ($rose(write_strobe_n_out) |=> write_strobe_n_out)
    else $error("write strobe high time too short");
  read_len_a: assert property ($fell(output_gate_n_out) |-> !output_gate_n_out [*2])
    else $error("read shorter than select access time");
  clear_len_a: assert property ($rose(hard_clear_n_out) |-> low_cnt >= CLEAR_PULSE_CYC)
    else $error("clear pulse shorter than minimum");
  recovery_a: assert property ($rose(hard_clear_n_out) |-> output_gate_n_out ##1 output_gate_n_out)
    else $error("read started inside clear recovery");
  prog_count_a: assert property (resp_valid_out && prog_op |-> n_wr == (byp_at ? 4'h2 : 4'h4))
    else $error("program used the wrong number of writes");

  // Main scenarios that the bench is expected to reach.
  cover property (!write_strobe_n_out);
  cover property ($fell(output_gate_n_out));
  cover property (resp_valid_out && prog_op && byp_at);
  cover property ($rose(hard_clear_n_out));
endmodule : flash_host_checker

bind flash_host_ctrl flash_host_checker chk (.mclk_in(mclk_in), .reset_in(reset_in),
  .req_valid_in(req_valid_in), .req_op_in(req_op_in), .req_ready_out(req_ready_out),
  .resp_valid_out(resp_valid_out), .bypass_mode_out(bypass_mode_out), .addr_out(addr_out),
  .chip_select_n_out(chip_select_n_out), .write_strobe_n_out(write_strobe_n_out),
  .output_gate_n_out(output_gate_n_out), .hard_clear_n_out(hard_clear_n_out),
  .data_pins_out(data_pins_out), .data_pins_oe_n_out(data_pins_oe_n_out));

/* verif/flash_dev_model.sv */
// Behavioural model of the parallel flash device on the far side of the host.
`timescale 1ns/1ns
module flash_dev_model
  import flash_host_pkg::*;
#(
  parameter logic [DATA_W-1:0] MAKER_CODE = 8'h5A,  // Arbitrary value.
  parameter logic [DATA_W-1:0] PART_CODE  = 8'hC3   // Arbitrary value.
)(
  // Pins from the host.
  input  wire logic [ADDR_W-1:0] addr_in,
  input  wire logic              chip_select_n_in,
  input  wire logic              write_strobe_n_in,
  input  wire logic              output_gate_n_in,
  input  wire logic              hard_clear_n_in,
  input  wire logic [DATA_W-1:0] data_in,
  input  wire logic              slow_in,
  // Pins to the host.
  output logic [DATA_W-1:0]      data_out,
  output logic                   ready_busy_out
);
  logic [DATA_W-1:0] mem [logic [ADDR_W-1:0]];
  logic [ADDR_W-1:0] wa, pa, kq[$];
  logic [DATA_W-1:0] pd;
  logic [31:0]       smask;
  logic              wact = 1'b0, busy = 1'b0, ident = 1'b0, byp = 1'b0, chip = 1'b0;
  int                seq = 0, kind = 0, opn = 0;

  assign ready_busy_out = !busy;

  // Status while busy, codes in identification mode, else the array.
  function automatic logic [DATA_W-1:0] rd_now(input logic [ADDR_W-1:0] a);
    if (busy) return {~pd[7], 7'h00};
    if (ident) return a[0] ? PART_CODE : MAKER_CODE;
    return mem.exists(a) ? mem[a] : 8'hFF;
  endfunction : rd_now

  // The operation runs on whether or not the device stays selected.
  task automatic finish_op(input int my);
    #(slow_in ? 5000 : 400);
    if (busy && my == opn) begin
      if (kind == 1) mem[pa] = (mem.exists(pa) ? mem[pa] : 8'hFF) & pd;
      foreach (mem[k]) if (kind == 2 && (chip || smask[k[20:16]])) kq.push_back(k);
      while (kq.size() > 0) mem.delete(kq.pop_front());
      busy = 1'b0;
    end
  endtask : finish_op

  task automatic start(input int k, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    kind = k;
    pa   = a;
    pd   = d;
    seq  = 0;
    busy = 1'b1;
    opn++;
    fork
      finish_op(opn);
    join_none
  endtask : start

  // Command decoder; a busy device takes only extra sectors for an erase.
  task automatic take_write(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    if (busy) begin
      if (kind == 2 && !chip && d == CMD_SECTOR_ERASE) smask[a[20:16]] = 1'b1;
    end else if (d == CMD_READ_ARRAY && seq != 3) begin
      ident = 1'b0;
      seq   = 0;
    end else begin
      case (seq)
        0: seq = byp ? ((d == CMD_PROGRAM) ? 3 : (d == CMD_BYPASS_EXIT0) ? 7 : 0)
                     : (d == UNLOCK_DATA_A && a == UNLOCK_ADDR_A) ? 1 : 0;
        1: seq = (d == UNLOCK_DATA_B && a == UNLOCK_ADDR_B) ? 2 : 0;
        2: begin
          ident = (d == CMD_IDENT);
          byp   = (d == CMD_BYPASS);
          seq   = (d == CMD_PROGRAM) ? 3 : (d == CMD_ERASE_SETUP) ? 4 : 0;
        end
        3: start(1, a, d);
        4: seq = (d == UNLOCK_DATA_A) ? 5 : 0;
        5: seq = (d == UNLOCK_DATA_B) ? 6 : 0;
        6: begin
          smask = '0;
          smask[a[20:16]] = (d == CMD_SECTOR_ERASE);
          chip = (d == CMD_CHIP_ERASE);
          start(2, a, 8'hFF);
        end
        default: begin
          byp = (d != CMD_BYPASS_EXIT1);
          seq = 0;
        end
      endcase
    end
  endtask : take_write

  // Address is taken when the last of strobe and select falls, data when the first rises.
  always @(write_strobe_n_in or chip_select_n_in) begin
    if (!write_strobe_n_in && !chip_select_n_in && output_gate_n_in && hard_clear_n_in) begin
      wa   = addr_in;
      wact = 1'b1;
    end else if (wact) begin
      wact = 1'b0;
      take_write(wa, data_in);
    end
  end

  // A clear ends all modes; aborting a running operation keeps the busy pin low a while.
  always @(negedge hard_clear_n_in) begin
    seq   = 0;
    ident = 1'b0;
    byp   = 1'b0;
    wact  = 1'b0;
    if (busy) begin
      opn++;
      #3000 busy = 1'b0;
    end
  end

  // Outputs show fresh data only after the access time; when off they show the inverse of the last value.
  always @(addr_in or chip_select_n_in or output_gate_n_in or write_strobe_n_in or hard_clear_n_in or busy) begin
    data_out <= ~data_out;
    if (!chip_select_n_in && !output_gate_n_in && write_strobe_n_in && hard_clear_n_in)
      data_out <= #(SELECT_ACCESS_NS) rd_now(addr_in);
  end

  initial data_out = 8'h00;
endmodule : flash_dev_model

/* verif/flash_bus_mode_control_tb_top.sv */
// Self-checking testbench of the flash host controller against the device model.
`timescale 1ns/1ns
module flash_bus_mode_control_tb_top
  import flash_host_pkg::*;
;
  localparam logic [DATA_W-1:0] MAKER = 8'h5A;  // Arbitrary value.
  localparam logic [DATA_W-1:0] PART  = 8'hC3;  // Arbitrary value.
  logic                mclk_in = 1'b0, reset_in = 1'b1, req_valid_in = 1'b0, req_more_in = 1'b0, slow = 1'b1;
  op_e                 req_op_in = OP_READ;
  logic [ADDR_W-1:0]   req_addr_in = '0;
  logic [DATA_W-1:0]   req_data_in = '0;
  logic [SECTOR_W-1:0] req_sector_in = '0;
  logic                req_ready_out, resp_valid_out, bypass_mode_out, ident_mode_out, interrupted_out;
  logic                cs_n, we_n, og_n, hc_n, oe_n, rb;
  logic [ADDR_W-1:0]   addr;
  logic [DATA_W-1:0]   resp_data_out, host_dq, dev_dq, bus;
  int                  n_errors = 0, checks_done = 0;

  // The shared data wire carries the host value while the host enables its drivers.
  assign bus = !oe_n ? host_dq : dev_dq;

  always #50 mclk_in = ~mclk_in;

  flash_host_ctrl DUT (.mclk_in(mclk_in), .reset_in(reset_in), .req_valid_in(req_valid_in),
    .req_op_in(req_op_in), .req_addr_in(req_addr_in), .req_data_in(req_data_in),
    .req_sector_in(req_sector_in), .req_more_in(req_more_in), .req_ready_out(req_ready_out),
    .resp_valid_out(resp_valid_out), .resp_data_out(resp_data_out), .bypass_mode_out(bypass_mode_out),
    .ident_mode_out(ident_mode_out), .interrupted_out(interrupted_out), .addr_out(addr),
    .chip_select_n_out(cs_n), .write_strobe_n_out(we_n), .output_gate_n_out(og_n), .hard_clear_n_out(hc_n),
    .data_pins_out(host_dq), .data_pins_oe_n_out(oe_n), .data_pins_in(bus), .ready_busy_in(rb));

  flash_dev_model #(.MAKER_CODE(MAKER), .PART_CODE(PART)) dev (.addr_in(addr), .chip_select_n_in(cs_n),
    .write_strobe_n_in(we_n), .output_gate_n_in(og_n), .hard_clear_n_in(hc_n), .data_in(bus),
    .slow_in(slow), .data_out(dev_dq), .ready_busy_out(rb));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // One request, then a bounded wait for its response pulse.
  task automatic op(input op_e o, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                    input logic [SECTOR_W-1:0] s = '0, input logic m = 1'b0);
    int i;
    @(posedge mclk_in);
    while (req_ready_out !== 1'b1) @(posedge mclk_in);
    req_valid_in  <= 1'b1;
    req_op_in     <= o;
    req_addr_in   <= a;
    req_data_in   <= d;
    req_sector_in <= s;
    req_more_in   <= m;
    @(posedge mclk_in);
    req_valid_in <= 1'b0;
    for (i = 0; i < 400 && resp_valid_out !== 1'b1; i++) @(posedge mclk_in);
    check(i < 400, 1'b1);
  endtask : op

  // The controller does not poll, so the bench waits on the busy pin.
  task automatic wait_rdy;
    int i;
    for (i = 0; i < 200 && rb !== 1'b1; i++) @(posedge mclk_in);
    check(rb, 1'b1);
  endtask : wait_rdy

  task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    op(OP_READ, a, 8'h00);
    check(resp_data_out, exp);
  endtask : rd_chk

  task automatic s_program;
    op(OP_PROGRAM, 21'h012345, 8'h3C);
    check(rb, 1'b0);
    op(OP_READ, 21'h012345, 8'h00);
    check(resp_data_out[7], 1'b1);
    wait_rdy();
    rd_chk(21'h012345, 8'h3C);
    rd_chk(21'h000000, 8'hFF);
  endtask : s_program

  task automatic s_ident;
    op(OP_IDENT, '0, 8'h00);
    check(ident_mode_out, 1'b1);
    rd_chk(21'h000000, MAKER);
    rd_chk(21'h000001, PART);
    op(OP_READ_ARRAY, '0, 8'h00);
    check(ident_mode_out, 1'b0);
    rd_chk(21'h012345, 8'h3C);
  endtask : s_ident

  // Two programs back to back in bypass mode; the checker counts two writes each.
  task automatic s_bypass;
    slow <= 1'b0;
    op(OP_BYPASS_ENTER, '0, 8'h00);
    check(bypass_mode_out, 1'b1);
    op(OP_PROGRAM, 21'h1F0001, 8'hA5);
    wait_rdy();
    op(OP_PROGRAM, 21'h1F0002, 8'h5A);
    wait_rdy();
    op(OP_BYPASS_EXIT, '0, 8'h00);
    check(bypass_mode_out, 1'b0);
    rd_chk(21'h1F0001, 8'hA5);
    rd_chk(21'h1F0002, 8'h5A);
  endtask : s_bypass

  // Bottom-ish and top sectors erased together, a neighbour kept, then the whole array.
  task automatic s_erase;
    op(OP_PROGRAM, 21'h050010, 8'h11);
    wait_rdy();
    op(OP_PROGRAM, 21'h060010, 8'h22);
    wait_rdy();
    slow <= 1'b1;
    op(OP_SECTOR_ERASE, '0, 8'h00, 5'h05);
    op(OP_SECTOR_ERASE, '0, 8'h00, 5'h1F, 1'b1);
    wait_rdy();
    rd_chk(21'h050010, 8'hFF);
    rd_chk(21'h1F0001, 8'hFF);
    rd_chk(21'h060010, 8'h22);
    op(OP_CHIP_ERASE, '0, 8'h00);
    wait_rdy();
    rd_chk(21'h060010, 8'hFF);
  endtask : s_erase

  // A clear in mid-program aborts it; the program is then run again.
  task automatic s_clear;
    op(OP_PROGRAM, 21'h000100, 8'h77);
    op(OP_CLEAR, '0, 8'h00);
    check(interrupted_out, 1'b1);
    check(rb, 1'b1);
    rd_chk(21'h000100, 8'hFF);
    op(OP_PROGRAM, 21'h000100, 8'h77);
    wait_rdy();
    rd_chk(21'h000100, 8'h77);
  endtask : s_clear

  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : stop_test

  // Main sequence.
  initial begin
    repeat (16) @(posedge mclk_in);
    reset_in <= 1'b0;
    op(OP_CLEAR, '0, 8'h00);
    check(interrupted_out, 1'b0);
    s_program();
    s_ident();
    s_bypass();
    s_erase();
    s_clear();
    stop_test();
  end

  // Watchdog: the sequence needs well under a third of this span.
  initial begin
    #3000000;
    n_errors++;
    stop_test();
  end
endmodule : flash_bus_mode_control_tb_top
